// ===== logic/vm_paging_defines.svh
`ifndef VM_PAGING_DEFINES_SVH
`define VM_PAGING_DEFINES_SVH

// register byte offsets, one 32-bit word each
`define OFS_ROOT_LO 8'h00
`define OFS_ROOT_HI 8'h04
`define OFS_TAG 8'h08
`define OFS_GAP 8'h0C
`define OFS_WINDOW 8'h10
`define OFS_FCV_LO 8'h14
`define OFS_FCV_HI 8'h18
`define OFS_LIST_LO 8'h1C
`define OFS_LIST_HI 8'h20
`define OFS_RBM_LO 8'h24
`define OFS_RBM_HI 8'h28
`define OFS_WBM_LO 8'h2C
`define OFS_WBM_HI 8'h30
`define OFS_VE_LO 8'h34
`define OFS_VE_HI 8'h38
`define OFS_INDEX 8'h3C
`define OFS_EXEC 8'h40
`define OFS_STATUS 8'h44
`define OFS_CAPS 8'h48

// root pointer fields
`define MT_MSB 2
`define MT_LSB 0
`define WALK_MSB 5
`define WALK_LSB 3
`define AD_BIT 6
`define RSVD_MSB 11
`define RSVD_LSB 7
`define BASE_LSB 12
`define MT_UNCACHED 3'h0
`define MT_WRITEBACK 3'h6

// function control vector and pointer list
`define FCV_SWITCH_BIT 0
`define LIST_ENTRIES 16'h0200

// execution control bits
`define EX_PAGING 0
`define EX_TAG 1
`define EX_PAUSE 2
`define EX_SECONDARY 3
`define EX_FUNC 4
`define EX_SHADOW 5
`define EX_VEXC 6
`define EX_WIDTH 7

// reset values
`define RST_REG64 64'h0000_0000_0000_0000
`define RST_REG32 32'h0000_0000
`define RST_REG16 16'h0000

`endif

// ===== logic/vm_paging_exec_controls.sv
`timescale 1ns/100ps
`default_nettype none
`include "vm_paging_defines.svh"
// How it works
// - low three bits: 0 uncached, 6 writeback
// - walk length is bits 5:3 plus one
// - bit 6 enables accessed and dirty flags
// - table base bits N-1:12, rest reserved
// - address width N reported in caps 7:0
// - software root pointer writes need paging support; pointer switching loads it regardless
// - 16-bit tag exists only with tag support
// - 32-bit gap limit between spin hints
// - 32-bit window limit on spin loop
// - pause limits counted on cycle stamp ticks
// - function vector needs secondary and function support
// - vector bit 0 permits pointer switching
// - reserved vector bits fail next entry
// - list address locates 512 eight-byte entries
// - shadow read and write bitmap addresses
// - shadowing on consults bitmaps for field ops
// - exception info stored at info address
// - exception reports the pointer index
// - pointer switching updates pointer index
module vm_paging_exec_controls #(
  parameter int PHYS_WIDTH = 36,
  parameter bit SUP_PAGING = 1'b1,
  parameter bit SUP_TAG = 1'b1,
  parameter bit SUP_PAUSE = 1'b1,
  parameter bit SUP_FUNC = 1'b1,
  parameter bit SUP_SHADOW = 1'b1,
  parameter bit SUP_VEXC = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // guest execution events
  input wire logic entry_req,
  input wire logic exit_req,
  input wire logic tick,
  input wire logic pause_hint,
  input wire logic switch_req,
  input wire logic [15:0] switch_sel,
  input wire logic [63:0] switch_entry,
  input wire logic field_op_req,
  input wire logic field_op_write,
  input wire logic [14:0] field_enc,
  input wire logic vexc_req,
  // results
  output logic guest_active,
  output logic entry_done,
  output logic entry_fail,
  output logic pause_exit,
  output logic switch_done,
  output logic switch_fault,
  output logic shadow_fetch_valid,
  output logic [63:0] shadow_fetch_addr,
  output logic [2:0] shadow_fetch_bit,
  output logic vexc_store_valid,
  output logic [63:0] vexc_store_addr,
  output logic [15:0] vexc_store_index,
  // translation view
  output logic [63:0] ept_root_pointer,
  output logic [3:0] walk_length,
  output logic mem_uncached,
  output logic mem_writeback,
  output logic ad_flags_en,
  output logic [15:0] virtual_cpu_tag,
  output logic [63:0] list_base
);

  logic [1:0] rst_sync_q;
  logic rst_ni;
  logic [63:0] fcv_q, list_q, rbm_q, wbm_q, vexc_q;
  logic [31:0] gap_q, window_q;
  logic [15:0] index_q;
  logic [`EX_WIDTH-1:0] exec_q;
  vm_paging_pkg::run_mode_t mode_q;
  logic bad_root_q, bad_fcv_q;
  logic [31:0] gap_cnt_q, win_cnt_q;
  logic in_loop_q;
  logic in_guest;
  logic switch_ok;
  logic [`EX_WIDTH-1:0] exec_sup;

  function automatic logic [63:0] put_half(input logic [63:0] old,
                                           input logic hi,
                                           input logic [31:0] w);
    logic [63:0] r;
    r = old;
    if (hi) begin
      r[63:32] = w;
    end else begin
      r[31:0] = w;
    end
    return r;
  endfunction

  // accepts only the encodings and reserved bits a walker can use
  function automatic logic root_ok(input logic [63:0] p);
    logic mt_ok;
    logic [63:0] above;
    mt_ok = (p[`MT_MSB:`MT_LSB] == `MT_UNCACHED) ||
            (p[`MT_MSB:`MT_LSB] == `MT_WRITEBACK);
    above = p >> PHYS_WIDTH;
    return mt_ok && (p[`RSVD_MSB:`RSVD_LSB] == 5'h00) &&
           (above == 64'h0);
  endfunction

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_ni = rst_sync_q[1];

  assign in_guest = (mode_q == vm_paging_pkg::MODE_GUEST);
  assign exec_sup = {SUP_VEXC, SUP_SHADOW, SUP_FUNC, SUP_FUNC,
                     SUP_PAUSE, SUP_TAG, SUP_PAGING};
  assign switch_ok = in_guest && exec_q[`EX_SECONDARY] &&
                     exec_q[`EX_FUNC] && fcv_q[`FCV_SWITCH_BIT] &&
                     (switch_sel < `LIST_ENTRIES) &&
                     root_ok(switch_entry);

  // root pointer: software writes, pointer switching replaces it
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      ept_root_pointer <= `RST_REG64;
    end else if (switch_req && switch_ok) begin
      ept_root_pointer <= switch_entry;
    end else if (SUP_PAGING && wr && (addr == `OFS_ROOT_LO ||
                                      addr == `OFS_ROOT_HI)) begin
      ept_root_pointer <= put_half(ept_root_pointer,
                                   addr == `OFS_ROOT_HI, wdata);
    end
  end

  // registered decode of the root pointer, one cycle behind it
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      walk_length <= 4'h1;
      mem_uncached <= 1'b1;
      mem_writeback <= 1'b0;
      ad_flags_en <= 1'b0;
    end else begin
      walk_length <= {1'b0, ept_root_pointer[`WALK_MSB:`WALK_LSB]}
                     + 4'h1;
      mem_uncached <= ept_root_pointer[`MT_MSB:`MT_LSB] ==
                      vm_paging_pkg::uncached_type;
      mem_writeback <= ept_root_pointer[`MT_MSB:`MT_LSB] ==
                       vm_paging_pkg::writeback_type;
      ad_flags_en <= ept_root_pointer[`AD_BIT];
    end
  end

  // plain control fields; a field the device lacks stays at zero
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      virtual_cpu_tag <= `RST_REG16;
      gap_q <= `RST_REG32;
      window_q <= `RST_REG32;
      fcv_q <= `RST_REG64;
      list_q <= `RST_REG64;
      rbm_q <= `RST_REG64;
      wbm_q <= `RST_REG64;
      vexc_q <= `RST_REG64;
      exec_q <= '0;
    end else if (wr) begin
      case (addr)
        `OFS_TAG: if (SUP_TAG) virtual_cpu_tag <= wdata[15:0];
        `OFS_GAP: if (SUP_PAUSE) gap_q <= wdata;
        `OFS_WINDOW: if (SUP_PAUSE) window_q <= wdata;
        `OFS_FCV_LO, `OFS_FCV_HI: begin
          if (SUP_FUNC) begin
            fcv_q <= put_half(fcv_q, addr == `OFS_FCV_HI, wdata);
          end
        end
        `OFS_LIST_LO, `OFS_LIST_HI: begin
          if (SUP_FUNC) begin
            list_q <= put_half(list_q, addr == `OFS_LIST_HI, wdata);
          end
        end
        `OFS_RBM_LO, `OFS_RBM_HI: begin
          if (SUP_SHADOW) begin
            rbm_q <= put_half(rbm_q, addr == `OFS_RBM_HI, wdata);
          end
        end
        `OFS_WBM_LO, `OFS_WBM_HI: begin
          if (SUP_SHADOW) begin
            wbm_q <= put_half(wbm_q, addr == `OFS_WBM_HI, wdata);
          end
        end
        `OFS_VE_LO, `OFS_VE_HI: begin
          if (SUP_VEXC) begin
            vexc_q <= put_half(vexc_q, addr == `OFS_VE_HI, wdata);
          end
        end
        `OFS_EXEC: exec_q <= wdata[`EX_WIDTH-1:0] & exec_sup;
        default: begin
        end
      endcase
    end
  end
  assign list_base = list_q;

  // switching wins over a software write in the same cycle
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      index_q <= `RST_REG16;
    end else if (switch_req && switch_ok) begin
      index_q <= switch_sel;
    end else if (SUP_VEXC && wr && addr == `OFS_INDEX) begin
      index_q <= wdata[15:0];
    end
  end

  // entry checks and guest mode
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      mode_q <= vm_paging_pkg::MODE_HOST;
      entry_done <= 1'b0;
      entry_fail <= 1'b0;
      bad_root_q <= 1'b0;
      bad_fcv_q <= 1'b0;
    end else begin
      entry_done <= 1'b0;
      entry_fail <= 1'b0;
      case (mode_q)
        vm_paging_pkg::MODE_HOST: begin
          if (entry_req) begin
            bad_root_q <= exec_q[`EX_PAGING] &&
                          !root_ok(ept_root_pointer);
            bad_fcv_q <= exec_q[`EX_SECONDARY] && exec_q[`EX_FUNC] &&
                         (fcv_q[63:1] != 63'h0);
            if ((exec_q[`EX_PAGING] && !root_ok(ept_root_pointer)) ||
                (exec_q[`EX_SECONDARY] && exec_q[`EX_FUNC] &&
                 fcv_q[63:1] != 63'h0)) begin
              entry_fail <= 1'b1;
            end else begin
              entry_done <= 1'b1;
              mode_q <= vm_paging_pkg::MODE_GUEST;
            end
          end
        end
        vm_paging_pkg::MODE_GUEST: begin
          if (exit_req || pause_exit) begin
            mode_q <= vm_paging_pkg::MODE_HOST;
          end
        end
        default: mode_q <= vm_paging_pkg::MODE_HOST;
      endcase
    end
  end
  assign guest_active = mode_q[1];

  // spin-hint loop detection on cycle stamp ticks
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      gap_cnt_q <= `RST_REG32;
      win_cnt_q <= `RST_REG32;
      in_loop_q <= 1'b0;
      pause_exit <= 1'b0;
    end else begin
      pause_exit <= 1'b0;
      if (!in_guest || !exec_q[`EX_PAUSE]) begin
        in_loop_q <= 1'b0;
        gap_cnt_q <= `RST_REG32;
        win_cnt_q <= `RST_REG32;
      end else if (pause_hint) begin
        gap_cnt_q <= `RST_REG32;
        if (!in_loop_q || gap_cnt_q > gap_q) begin
          in_loop_q <= 1'b1;
          win_cnt_q <= `RST_REG32;
        end else if (win_cnt_q > window_q) begin
          pause_exit <= 1'b1;
          in_loop_q <= 1'b0;
        end
      end else if (tick) begin
        gap_cnt_q <= sat_inc(gap_cnt_q);
        win_cnt_q <= sat_inc(win_cnt_q);
      end
    end
  end

  // pointer switching results
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      switch_done <= 1'b0;
      switch_fault <= 1'b0;
    end else begin
      switch_done <= switch_req && switch_ok;
      switch_fault <= switch_req && !switch_ok;
    end
  end

  // bitmap byte holding the field's bit; 32 KBits need 15-bit encodings
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      shadow_fetch_valid <= 1'b0;
      shadow_fetch_addr <= `RST_REG64;
      shadow_fetch_bit <= 3'h0;
    end else begin
      shadow_fetch_valid <= field_op_req && in_guest &&
                            exec_q[`EX_SHADOW];
      if (field_op_req) begin
        shadow_fetch_addr <= (field_op_write ? wbm_q : rbm_q) +
                             {52'h0, field_enc[14:3]};
        shadow_fetch_bit <= field_enc[2:0];
      end
    end
  end

  // exception store request
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      vexc_store_valid <= 1'b0;
      vexc_store_addr <= `RST_REG64;
      vexc_store_index <= `RST_REG16;
    end else begin
      vexc_store_valid <= vexc_req && in_guest && exec_q[`EX_VEXC];
      if (vexc_req) begin
        vexc_store_addr <= vexc_q;
        vexc_store_index <= index_q;
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      rdata <= `RST_REG32;
    end else if (rd) begin
      case (addr)
        `OFS_ROOT_LO: rdata <= ept_root_pointer[31:0];
        `OFS_ROOT_HI: rdata <= ept_root_pointer[63:32];
        `OFS_TAG: rdata <= {16'h0000, virtual_cpu_tag};
        `OFS_GAP: rdata <= gap_q;
        `OFS_WINDOW: rdata <= window_q;
        `OFS_FCV_LO: rdata <= fcv_q[31:0];
        `OFS_FCV_HI: rdata <= fcv_q[63:32];
        `OFS_LIST_LO: rdata <= list_q[31:0];
        `OFS_LIST_HI: rdata <= list_q[63:32];
        `OFS_RBM_LO: rdata <= rbm_q[31:0];
        `OFS_RBM_HI: rdata <= rbm_q[63:32];
        `OFS_WBM_LO: rdata <= wbm_q[31:0];
        `OFS_WBM_HI: rdata <= wbm_q[63:32];
        `OFS_VE_LO: rdata <= vexc_q[31:0];
        `OFS_VE_HI: rdata <= vexc_q[63:32];
        `OFS_INDEX: rdata <= {16'h0000, index_q};
        `OFS_EXEC: rdata <= {25'h0, exec_q};
        `OFS_STATUS: rdata <= {24'h0, walk_length, bad_fcv_q,
                               bad_root_q, in_loop_q, guest_active};
        // software checks these bits before enabling features
        `OFS_CAPS: rdata <= {17'h0, exec_sup,
                             8'(PHYS_WIDTH)};
        default: rdata <= `RST_REG32;
      endcase
    end else begin
      rdata <= `RST_REG32;
    end
  end

endmodule
`default_nettype wire

// ===== logic/vm_paging_pkg.sv
`default_nettype none
package vm_paging_pkg;

  typedef enum logic [1:0] {
    MODE_HOST = 2'b01,
    MODE_GUEST = 2'b10
  } run_mode_t;

  typedef enum logic [2:0] {
    uncached_type = 3'h0,
    writeback_type = 3'h6
  } mem_type_t;

endpackage
`default_nettype wire

// ===== verification/vm_paging_exec_controls_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "vm_paging_defines.svh"
module vm_paging_exec_controls_bench;
  localparam int EN = 0, EX = 1, TK = 2, PH = 3, SW = 4, FO = 5, VX = 6;
  logic clk, rst_n, wr, rd, field_op_write, guest_active, entry_done;
  logic entry_req, exit_req, tick, pause_hint, switch_req, field_op_req;
  logic vexc_req, entry_fail, pause_exit, switch_done, switch_fault;
  logic shadow_fetch_valid, vexc_store_valid;
  logic mem_uncached, mem_writeback, ad_flags_en;
  logic [6:0] ev;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] switch_sel, virtual_cpu_tag, vexc_store_index;
  logic [63:0] switch_entry, shadow_fetch_addr, vexc_store_addr;
  logic [63:0] ept_root_pointer, list_base;
  logic [14:0] field_enc;
  logic [2:0] shadow_fetch_bit;
  logic [3:0] walk_length;
  int errors, n_tests;
  // one event vector keeps every pulse on a single driver
  assign {vexc_req, field_op_req, switch_req, pause_hint} = ev[6:3];
  assign {tick, exit_req, entry_req} = ev[2:0];

  vm_paging_exec_controls dut_u (.clk, .rst_n, .addr, .wdata, .wr, .rd,
    .rdata, .entry_req, .exit_req, .tick, .pause_hint, .switch_req,
    .switch_sel, .switch_entry, .field_op_req, .field_op_write, .field_enc,
    .vexc_req, .guest_active, .entry_done, .entry_fail, .pause_exit,
    .switch_done, .switch_fault, .shadow_fetch_valid, .shadow_fetch_addr,
    .shadow_fetch_bit, .vexc_store_valid, .vexc_store_addr,
    .vexc_store_index, .ept_root_pointer, .walk_length, .mem_uncached,
    .mem_writeback, .ad_flags_en, .virtual_cpu_tag, .list_base);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic fire(int k);
    @(posedge clk);
    ev <= 7'h01 << k;
    @(posedge clk);
    ev <= 7'h00;
    #1;
  endtask
  function automatic logic [31:0] pat(int a);
    return {8'hA5, a[7:0], 8'h3C, ~a[7:0]};
  endfunction
  function automatic logic [31:0] rb(int a);
    if (a == 'h08 || a == 'h3C) return pat(a) & 32'h0000_FFFF;
    if (a == 'h40) return pat(a) & 32'h0000_007F;
    if (a == 'h44) return 32'h0000_0080;
    if (a == 'h48) return 32'h0000_7F24;
    return (a < 'h44) ? pat(a) : 32'h0;
  endfunction

  task automatic t_regs;
    logic [31:0] d;
    for (int a = 0; a <= 'h4C; a += 4) begin
      rreg(a[7:0], d);
      chk("reset read", (a == 'h44) ? 32'h10 : (a == 'h48) ? rb(a) : 0, d);
    end
    // all writes after the reset reads, so status then shows the walk length of the written root
    for (int a = 0; a <= 'h4C; a += 4) begin
      wreg(a[7:0], pat(a));
    end
    for (int a = 0; a <= 'h4C; a += 4) begin
      rreg(a[7:0], d);
      chk("read back", rb(a), d);
    end
    chk("tag port", rb('h08), virtual_cpu_tag);
    chk("list port", {pat('h20), pat('h1C)}, list_base);
    chk("root port", {pat('h04), pat('h00)}, ept_root_pointer);
    rreg(`OFS_CAPS, d);
    chk("caps", 32'h0000_7F24, d);
    $display("t_regs done");
  endtask
  task automatic t_decode;
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      wreg(`OFS_ROOT_LO, {25'h0, m[0], m ^ 3'h5, m});
      @(posedge clk);
      #1;
      chk("uncached", m == 3'h0, mem_uncached);
      chk("writeback", m == 3'h6, mem_writeback);
      chk("walk", {1'b0, m ^ 3'h5} + 4'h1, walk_length);
      chk("ad flags", m[0], ad_flags_en);
    end
    $display("t_decode done");
  endtask
  task automatic t_entry;
    logic [31:0] lo[5] = '{32'h1003, 32'h1086, 32'h1006, 32'h1006, 32'h101E};
    logic [31:0] hi[5] = '{32'h0, 32'h0, 32'h10, 32'h0, 32'hF};
    logic [31:0] fv[5] = '{32'h1, 32'h1, 32'h1, 32'h2, 32'h1};
    wreg(`OFS_EXEC, 32'h7F);
    wreg(`OFS_FCV_HI, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wreg(`OFS_ROOT_LO, lo[i]);
      wreg(`OFS_ROOT_HI, hi[i]);
      wreg(`OFS_FCV_LO, fv[i]);
      fire(EN);
      chk("entry done", i == 4, entry_done);
      chk("entry fail", i != 4, entry_fail);
    end
    chk("guest", 1, guest_active);
    fire(EN);
    chk("entry in guest", 0, entry_done);
    $display("t_entry done");
  endtask
  task automatic do_sw(logic [15:0] s, logic [63:0] e, logic ok);
    @(posedge clk);
    switch_sel <= s;
    switch_entry <= e;
    fire(SW);
    chk("switch done", ok, switch_done);
    chk("switch fault", !ok, switch_fault);
  endtask
  task automatic t_switch;
    wreg(`OFS_VE_LO, 32'h8000);
    wreg(`OFS_VE_HI, 32'h1);
    do_sw(16'h0005, 64'h2_0000_301E, 1'b1);
    chk("switched root", 64'h2_0000_301E, ept_root_pointer);
    do_sw(16'h0200, 64'h2_0000_301E, 1'b0);
    do_sw(16'h0006, 64'h2_0000_3002, 1'b0);
    do_sw(16'h0007, 64'h10_0000_3006, 1'b0);
    fire(VX);
    chk("vexc valid", 1, vexc_store_valid);
    chk("vexc addr", 64'h1_0000_8000, vexc_store_addr);
    chk("vexc index", 16'h0005, vexc_store_index);
    $display("t_switch done");
  endtask
  task automatic t_shadow;
    wreg(`OFS_RBM_LO, 32'h4000);
    wreg(`OFS_RBM_HI, 32'h0);
    wreg(`OFS_WBM_LO, 32'h9000);
    wreg(`OFS_WBM_HI, 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      field_op_write <= i[0];
      field_enc <= i[0] ? 15'h7FFD : 15'h0013;
      fire(FO);
      chk("shadow valid", 1, shadow_fetch_valid);
      chk("shadow addr", i ? 64'h9FFF : 64'h4002, shadow_fetch_addr);
      chk("shadow bit", i ? 3'h5 : 3'h3, shadow_fetch_bit);
    end
    $display("t_shadow done");
  endtask
  task automatic t_pause;
    wreg(`OFS_GAP, 32'h2);
    wreg(`OFS_WINDOW, 32'h3);
    fire(PH);
    repeat (3) fire(TK);
    // a gap above the limit must restart the loop and its window
    fire(PH);
    chk("gap restart", 0, pause_exit);
    for (int k = 1; k <= 4; k++) begin
      fire(TK);
      fire(PH);
      chk("pause exit", k == 4, pause_exit);
    end
    @(posedge clk);
    #1;
    chk("guest left", 0, guest_active);
    $display("t_pause done");
  endtask
  task automatic t_exit;
    // outside guest mode a valid pointer switch must still be refused
    do_sw(16'h0005, 64'h2_0000_301E, 1'b0);
    fire(EN);
    chk("second entry", 1, entry_done);
    fire(EX);
    chk("exit", 0, guest_active);
    $display("t_exit done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #20000;
    errors++;
    final_report;
  end

  initial begin
    rst_n = 1'b0;
    ev = 7'h00;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    switch_sel = 16'h0;
    switch_entry = 64'h0;
    field_op_write = 1'b0;
    field_enc = 15'h0;
    errors = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_decode;
    t_entry;
    t_switch;
    t_shadow;
    t_pause;
    t_exit;
    final_report;
  end
endmodule
`default_nettype wire

// ===== verification/vm_paging_exec_controls_sva.sv
`timescale 1ns/100ps
`default_nettype none
module vm_paging_exec_controls_sva #(
  parameter int PHYS_WIDTH = 36
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic entry_req,
  input wire logic pause_hint,
  input wire logic switch_req,
  input wire logic [15:0] switch_sel,
  input wire logic [63:0] switch_entry,
  input wire logic field_op_req,
  input wire logic [14:0] field_enc,
  input wire logic vexc_req,
  input wire logic guest_active,
  input wire logic entry_done,
  input wire logic entry_fail,
  input wire logic pause_exit,
  input wire logic switch_done,
  input wire logic switch_fault,
  input wire logic shadow_fetch_valid,
  input wire logic [2:0] shadow_fetch_bit,
  input wire logic vexc_store_valid,
  input wire logic [63:0] ept_root_pointer,
  input wire logic [3:0] walk_length,
  input wire logic mem_uncached,
  input wire logic mem_writeback,
  input wire logic ad_flags_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_entry_taken;
    entry_req && !guest_active;
  endsequence
  sequence s_switch_ok;
    switch_req ##1 switch_done;
  endsequence

  chk_read_idle:
    assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  chk_type_decode:
    assert property (mem_writeback == ($past(ept_root_pointer[2:0]) == 3'h6)
      && mem_uncached == ($past(ept_root_pointer[2:0]) == 3'h0))
    else $error("memory type decode wrong");
  chk_walk_decode:
    assert property (walk_length ==
      {1'b0, $past(ept_root_pointer[5:3])} + 4'h1)
    else $error("walk length decode wrong");
  chk_ad_decode:
    assert property (ad_flags_en == $past(ept_root_pointer[6]))
    else $error("accessed dirty enable wrong");
  chk_entry_answer:
    assert property (s_entry_taken |=> entry_done != entry_fail)
    else $error("entry not answered once");
  chk_switch_root:
    assert property (s_switch_ok |-> ept_root_pointer == $past(switch_entry))
    else $error("switch did not load root");
  chk_switch_range:
    assert property (switch_req && switch_sel >= 16'h0200
      |=> switch_fault && !switch_done)
    else $error("switch beyond list accepted");
  chk_switch_width:
    assert property (switch_req && (switch_entry >> PHYS_WIDTH) != 64'h0
      |=> switch_fault)
    else $error("switch with wide address accepted");
  chk_switch_type:
    assert property (switch_req && !(switch_entry[2:0] inside {3'h0, 3'h6})
      |=> switch_fault)
    else $error("switch with reserved type accepted");
  chk_shadow_bit:
    assert property (shadow_fetch_valid |->
      $past(field_op_req) && shadow_fetch_bit == $past(field_enc[2:0]))
    else $error("shadow fetch without cause");
  chk_vexc_cause:
    assert property (vexc_store_valid |-> $past(vexc_req) && $past(guest_active))
    else $error("exception store without cause");
  chk_pause_exit:
    assert property (pause_exit |-> $past(pause_hint) ##1 !guest_active)
    else $error("pause exit wrong");
endmodule
bind vm_paging_exec_controls vm_paging_exec_controls_sva #(
  .PHYS_WIDTH(PHYS_WIDTH)) chk_u (.clk, .rst_n, .rd, .rdata, .entry_req,
  .pause_hint, .switch_req, .switch_sel, .switch_entry, .field_op_req,
  .field_enc, .vexc_req, .guest_active, .entry_done, .entry_fail,
  .pause_exit, .switch_done, .switch_fault, .shadow_fetch_valid,
  .shadow_fetch_bit, .vexc_store_valid, .ept_root_pointer, .walk_length,
  .mem_uncached, .mem_writeback, .ad_flags_en);
`default_nettype wire
